// ---- rtl/eb_pkg.sv ----
// Purpose: Shared constants for the external bus pin block.
// Assumes: A 40 MHz reference clock; shared and output-only strobe pins double as port bits.
// Notes:   Shared pin indices select one bit of the shared pin vectors.
package eb_pkg;

    // Clock period and bus phase times.
    localparam int CLK_PERIOD_PS = 25000;
    localparam int T_ADDR_NS     = 25;
    localparam int T_STROBE_NS   = 50;

    // Phase lengths in cycles, least times rounded up, at least one.
    localparam int ADDR_CYC_I   = (T_ADDR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int STROBE_CYC_I = (T_STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [2:0] ADDR_LAST   = 3'(((ADDR_CYC_I < 1) ? 1 : ADDR_CYC_I) - 1);
    localparam logic [2:0] STROBE_LAST = 3'(((STROBE_CYC_I < 1) ? 1 : STROBE_CYC_I) - 1);
    localparam logic [2:0] CNT_ZERO    = 3'h0;

    // Cycles after reset release before the mode pin filter is settled.
    localparam logic [1:0] MODE_SETTLE = 2'h3;

    // Widths.
    localparam int ADDR_W   = 24;
    localparam int SHARED_W = 8;
    localparam int FSEL_W   = 10;

    // Shared bidirectional pin indices.
    localparam int IDX_WRITE_HIGH = 0;
    localparam int IDX_WAIT       = 1;
    localparam int IDX_BUS_REQ    = 2;
    localparam int IDX_BUS_GRANT  = 3;
    localparam int IDX_DIRECTION  = 4;
    localparam int IDX_MODE       = 5;
    localparam int IDX_CS_ZERO    = 6;
    localparam int IDX_CS_ONE     = 7;

    // Function select indices of the two output-only pins.
    localparam int IDX_READ_STROBE = 8;
    localparam int IDX_WRITE_LOW   = 9;

    // Reset values.
    localparam logic [FSEL_W-1:0] FSEL_RESET = 10'h000;
    localparam logic              PIN_IDLE   = 1'b1;

    // Bus sequencer states, Gray coded along the access path.
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_DATA  = 3'h3,
        ST_DONE  = 3'h2,
        ST_REL   = 3'h6,
        ST_GRANT = 3'h7
    } eb_state_t;

endpackage

// ---- rtl/eb_pin_cell.sv ----
// Purpose: One shared pin: port bit or bus function, with input filter.
// Assumes: The pin comes from outside the clock domain.
// Notes:   The pull-up is enabled whenever the pin is not driven.
`timescale 1ns/1ps
module eb_pin_cell
(
    // Clock and reset.
    input  wire logic ref_clk,
    input  wire logic rst_b,
    // Function select.
    input  wire logic func_sel,
    // Bus function side.
    input  wire logic bus_o,
    input  wire logic bus_oe,
    // Port function side.
    input  wire logic port_o,
    input  wire logic port_oe,
    // Pin side.
    input  wire logic pin_i,
    output logic      pin_o,
    output logic      pin_oe,
    output logic      pin_pu,
    // Filtered pin level.
    output logic      level
);

    logic sync1_q;
    logic sync2_q;
    logic sync3_q;
    logic level_q;

    // Select the driver of the pin from the function select bit.
    assign pin_o  = func_sel ? bus_o : port_o;
    assign pin_oe = func_sel ? bus_oe : port_oe;
    assign pin_pu = ~pin_oe;
    assign level  = level_q;

    // Synchroniser chain; the first stage feeds only the second.
    always_ff @(posedge ref_clk)
    begin
        sync1_q <= pin_i;
        sync2_q <= sync1_q;
        sync3_q <= sync2_q;
    end

    // A change counts once the second and third stages agree.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            level_q <= eb_pkg::PIN_IDLE;
        else if (sync2_q == sync3_q)
            level_q <= sync3_q;
    end

endmodule

// ---- rtl/eb_bus_pins.sv ----
// Purpose: External memory bus pin logic with port sharing and handover.
// Assumes: The core issues one access at a time on the request port.
// Notes:   Wait, bus request and the mode pin pass a three-stage filter.
// Behaviour
// - Read strobe low during every read.
// - Low write strobe for writes on low lane.
// - High write strobe for writes on high lane.
// - Active wait input stalls the bus access.
// - Release bus, then assert bus acknowledge.
// - Direction high on read or dummy, low on write.
// - Sample mode pin at reset release; high means normal.
// - Chip select low inside its range, else high.
// - Read and low write pins are output-only.
// - Other shared pins bidirectional with pull-up.
// - Address bits 0-7 and 16-23 dedicated outputs.
// - Low data lines carry address, then data.
`timescale 1ns/1ps
module eb_bus_pins
(
    // Clock and reset.
    input  wire logic                      ref_clk,
    input  wire logic                      rst_b,
    // Core access request.
    input  wire logic                      req_valid,
    output logic                           req_ready,
    input  wire logic                      req_write,
    input  wire logic                      req_dummy,
    input  wire logic [1:0]                req_lanes,
    input  wire logic [eb_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [15:0]               req_wdata,
    // Core access answer.
    output logic                           resp_valid,
    output logic [15:0]                    resp_rdata,
    // Pin function and port control.
    input  wire logic [eb_pkg::FSEL_W-1:0] func_sel_in,
    input  wire logic                      func_sel_load,
    input  wire logic                      port3_output_bit_zero,
    input  wire logic                      port3_output_bit_one,
    input  wire logic [7:0]                port_out_in,
    input  wire logic [7:0]                port_dir_in,
    output logic [7:0]                     port_level_out,
    // Chip select ranges on address bits 23 to 16.
    input  wire logic [7:0]                cs0_base_in,
    input  wire logic [7:0]                cs0_mask_in,
    input  wire logic [7:0]                cs1_base_in,
    input  wire logic [7:0]                cs1_mask_in,
    // Operating mode caught at reset release.
    output logic                           normal_mode_out,
    // Dedicated address pins.
    output logic [7:0]                     address_low_out,
    output logic [7:0]                     address_high_out,
    output logic                           address_oe,
    output logic                           addr_latch_out,
    // Output-only strobe pins.
    output logic                           read_strobe_n,
    output logic                           write_strobe_low_n,
    // Multiplexed address and data pins.
    input  wire logic [7:0]                muxed_addr_data_low_i,
    output logic [7:0]                     muxed_addr_data_low_o,
    output logic                           muxed_addr_data_low_oe,
    input  wire logic [7:0]                muxed_addr_data_high_i,
    output logic [7:0]                     muxed_addr_data_high_o,
    output logic                           muxed_addr_data_high_oe,
    // Shared bidirectional pins.
    input  wire logic [7:0]                shared_pin_i,
    output logic [7:0]                     shared_pin_o,
    output logic [7:0]                     shared_pin_oe,
    output logic [7:0]                     shared_pin_pu
);

    eb_pkg::eb_state_t state_q;
    eb_pkg::eb_state_t state_d;

    logic [eb_pkg::FSEL_W-1:0] func_sel_q;
    logic [eb_pkg::ADDR_W-1:0] addr_q;
    logic [15:0]               wdata_q;
    logic [15:0]               rdata_q;
    logic [1:0]                lanes_q;
    logic [2:0]                cnt_q;
    logic [2:0]                cnt_d;
    logic [1:0]                mode_cnt_q;
    logic                      mode_taken_q;
    logic                      mode_q;
    logic                      wr_q;
    logic                      dummy_q;
    logic                      cs0_hit_q;
    logic                      cs1_hit_q;

    logic [7:0] level;
    logic [7:0] bus_o;
    logic [7:0] bus_oe;
    logic       wait_in_n;
    logic       bus_request_in_n;
    logic       stall;
    logic       take;
    logic       own_bus;
    logic       in_access;
    logic       in_data;
    logic       data_end;
    logic       write_strobe_high_n;
    logic       bus_grant_out_n;
    logic       rw_level;
    logic       chip_select_zero_n;
    logic       chip_select_one_n;
    logic       bus_read_n;
    logic       bus_write_low_n;

    // Filtered levels of the shared input functions.
    assign wait_in_n        = level[eb_pkg::IDX_WAIT];
    assign bus_request_in_n = level[eb_pkg::IDX_BUS_REQ];
    assign port_level_out   = level;

    // Sequencer status decode.
    assign stall     = ~wait_in_n;
    assign own_bus   = (state_q != eb_pkg::ST_REL) && (state_q != eb_pkg::ST_GRANT);
    assign in_access = (state_q == eb_pkg::ST_ADDR) || (state_q == eb_pkg::ST_DATA);
    assign in_data   = (state_q == eb_pkg::ST_DATA);
    assign data_end  = in_data && (cnt_q == eb_pkg::CNT_ZERO) && !stall;
    assign req_ready = (state_q == eb_pkg::ST_IDLE) && bus_request_in_n;
    assign take      = req_valid && req_ready;

    // Strobes and direction decoded from the sequencer state.
    assign bus_read_n          = ~(in_data && !wr_q && !dummy_q);
    assign bus_write_low_n     = ~(in_data && wr_q && lanes_q[0]);
    assign write_strobe_high_n = ~(in_data && wr_q && lanes_q[1]);
    assign rw_level            = ~(wr_q && state_q != eb_pkg::ST_IDLE && own_bus);
    assign chip_select_zero_n  = ~(in_access && cs0_hit_q);
    assign chip_select_one_n   = ~(in_access && cs1_hit_q);
    assign bus_grant_out_n     = ~(state_q == eb_pkg::ST_GRANT);

    // Output-only pins: bus strobe or port bit, never an input.
    assign read_strobe_n      = func_sel_q[eb_pkg::IDX_READ_STROBE] ? bus_read_n
                                : port3_output_bit_zero;
    assign write_strobe_low_n = func_sel_q[eb_pkg::IDX_WRITE_LOW] ? bus_write_low_n
                                : port3_output_bit_one;

    // Bus function values of the shared pins.
    assign bus_o = {chip_select_one_n, chip_select_zero_n, eb_pkg::PIN_IDLE, rw_level,
                    bus_grant_out_n, eb_pkg::PIN_IDLE, eb_pkg::PIN_IDLE,
                    write_strobe_high_n};
    assign bus_oe = {own_bus, own_bus, 1'b0, own_bus, 1'b1, 1'b0, 1'b0, own_bus};

    // Dedicated address and multiplexed lanes.
    assign address_low_out         = addr_q[7:0];
    assign address_high_out        = addr_q[23:16];
    assign address_oe              = own_bus;
    assign addr_latch_out          = (state_q == eb_pkg::ST_ADDR);
    assign muxed_addr_data_low_o   = in_data ? wdata_q[7:0] : addr_q[7:0];
    assign muxed_addr_data_high_o  = in_data ? wdata_q[15:8] : addr_q[15:8];
    assign muxed_addr_data_low_oe  = (state_q == eb_pkg::ST_ADDR) || (in_data && wr_q);
    assign muxed_addr_data_high_oe = muxed_addr_data_low_oe;

    // Answer to the core.
    assign resp_valid      = (state_q == eb_pkg::ST_DONE);
    assign resp_rdata      = rdata_q;
    assign normal_mode_out = mode_q;

    // One cell per shared pin, each with its own function select bit.
    genvar gi;
    generate
        for (gi = 0; gi < eb_pkg::SHARED_W; gi++)
        begin : g_pin
            eb_pin_cell u_cell
            (
                .ref_clk  (ref_clk),
                .rst_b    (rst_b),
                .func_sel (func_sel_q[gi]),
                .bus_o    (bus_o[gi]),
                .bus_oe   (bus_oe[gi]),
                .port_o   (port_out_in[gi]),
                .port_oe  (port_dir_in[gi]),
                .pin_i    (shared_pin_i[gi]),
                .pin_o    (shared_pin_o[gi]),
                .pin_oe   (shared_pin_oe[gi]),
                .pin_pu   (shared_pin_pu[gi]),
                .level    (level[gi])
            );
        end
    endgenerate

    // Next state of the sequencer and its phase counter.
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        case (state_q)
            eb_pkg::ST_IDLE:
            begin
                if (!bus_request_in_n)
                    state_d = eb_pkg::ST_REL;
                else if (take)
                begin
                    state_d = eb_pkg::ST_ADDR;
                    cnt_d   = eb_pkg::ADDR_LAST;
                end
            end
            eb_pkg::ST_ADDR:
            begin
                if (cnt_q == eb_pkg::CNT_ZERO)
                begin
                    state_d = eb_pkg::ST_DATA;
                    cnt_d   = eb_pkg::STROBE_LAST;
                end
                else
                    cnt_d = cnt_q - 3'h1;
            end
            eb_pkg::ST_DATA:
            begin
                if (data_end)
                    state_d = eb_pkg::ST_DONE;
                else if (!stall && cnt_q != eb_pkg::CNT_ZERO)
                    cnt_d = cnt_q - 3'h1;
            end
            eb_pkg::ST_DONE:
                state_d = eb_pkg::ST_IDLE;
            eb_pkg::ST_REL:
                state_d = eb_pkg::ST_GRANT;
            eb_pkg::ST_GRANT:
            begin
                if (bus_request_in_n)
                    state_d = eb_pkg::ST_IDLE;
            end
            default:
                state_d = eb_pkg::ST_IDLE;
        endcase
    end

    // Sequencer registers.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= eb_pkg::ST_IDLE;
            cnt_q   <= eb_pkg::CNT_ZERO;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    // Access attributes latched when a request is taken.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_q    <= 24'h00_0000;
            wdata_q   <= 16'h0000;
            lanes_q   <= 2'h0;
            wr_q      <= 1'b0;
            dummy_q   <= 1'b0;
            cs0_hit_q <= 1'b0;
            cs1_hit_q <= 1'b0;
        end
        else if (take)
        begin
            addr_q    <= req_addr;
            wdata_q   <= req_wdata;
            lanes_q   <= req_lanes;
            wr_q      <= req_write;
            dummy_q   <= req_dummy && !req_write;
            cs0_hit_q <= ((req_addr[23:16] ^ cs0_base_in) & cs0_mask_in) == 8'h00;
            cs1_hit_q <= ((req_addr[23:16] ^ cs1_base_in) & cs1_mask_in) == 8'h00;
        end
    end

    // Read data caught on the edge that ends the strobe.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_q <= 16'h0000;
        else if (data_end && !wr_q)
            rdata_q <= {muxed_addr_data_high_i, muxed_addr_data_low_i};
    end

    // Function select bits, all port function after reset.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            func_sel_q <= eb_pkg::FSEL_RESET;
        else if (func_sel_load)
            func_sel_q <= func_sel_in;
    end

    // Mode pin caught once its filter has settled after reset release.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mode_cnt_q   <= 2'h0;
            mode_taken_q <= 1'b0;
            mode_q       <= 1'b0;
        end
        else if (!mode_taken_q)
        begin
            mode_cnt_q <= mode_cnt_q + 2'h1;
            if (mode_cnt_q == eb_pkg::MODE_SETTLE)
            begin
                mode_taken_q <= 1'b1;
                mode_q       <= level[eb_pkg::IDX_MODE];
            end
        end
    end

    // Checks on the pin behaviour.
    property p_read_strobe;
        @(posedge ref_clk) disable iff (!rst_b)
        (in_data && !wr_q && !dummy_q && func_sel_q[eb_pkg::IDX_READ_STROBE])
        |-> !read_strobe_n && rw_level;
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("read strobe not low");

    property p_write_low;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(in_data) && wr_q && lanes_q[0] && func_sel_q[eb_pkg::IDX_WRITE_LOW]
        |-> !write_strobe_low_n [*2];
    endproperty
    a_write_low: assert property (p_write_low) else $error("low write strobe short");

    property p_write_high;
        @(posedge ref_clk) disable iff (!rst_b)
        (in_data && wr_q && !lanes_q[1]) |-> write_strobe_high_n;
    endproperty
    a_write_high: assert property (p_write_high) else $error("high strobe wrong lane");

    property p_wait_hold;
        @(posedge ref_clk) disable iff (!rst_b)
        (in_data && stall) |=> in_data && $stable(cnt_q);
    endproperty
    a_wait_hold: assert property (p_wait_hold) else $error("access moved during wait");

    property p_grant;
        @(posedge ref_clk) disable iff (!rst_b)
        $fell(bus_grant_out_n) |-> $past(!address_oe) && !shared_pin_oe[eb_pkg::IDX_CS_ZERO];
    endproperty
    a_grant: assert property (p_grant) else $error("grant before release");

    property p_direction;
        @(posedge ref_clk) disable iff (!rst_b)
        (state_q == eb_pkg::ST_ADDR && wr_q) |-> !rw_level ##1 (in_data && !rw_level);
    endproperty
    a_direction: assert property (p_direction) else $error("direction high on write");

    property p_mode;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(mode_taken_q) |-> mode_q == $past(level[eb_pkg::IDX_MODE]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not caught from pin");

    property p_chip_select;
        @(posedge ref_clk) disable iff (!rst_b)
        (state_q == eb_pkg::ST_IDLE) |-> chip_select_zero_n && chip_select_one_n;
    endproperty
    a_chip_select: assert property (p_chip_select) else $error("select low when idle");

    property p_port_pin;
        @(posedge ref_clk) disable iff (!rst_b)
        !func_sel_q[eb_pkg::IDX_WAIT] |-> shared_pin_oe[eb_pkg::IDX_WAIT]
            == port_dir_in[eb_pkg::IDX_WAIT];
    endproperty
    a_port_pin: assert property (p_port_pin) else $error("port direction ignored");

    property p_addr_mux;
        @(posedge ref_clk) disable iff (!rst_b)
        $rose(addr_latch_out) |-> muxed_addr_data_low_oe
            && muxed_addr_data_low_o == address_low_out;
    endproperty
    a_addr_mux: assert property (p_addr_mux) else $error("address phase missing");

    property p_func_sel;
        @(posedge ref_clk) disable iff (!rst_b)
        func_sel_load |=> func_sel_q == $past(func_sel_in);
    endproperty
    a_func_sel: assert property (p_func_sel) else $error("function select not loaded");

endmodule

// ---- tb/eb_mem_model.sv ----
// Purpose: Far-side memory for the external bus pin block.
// Assumes: One memory on chip select zero; a read returns the inverted address.
// Notes:   An undriven data bus shows a changing pattern, never a held value.
`timescale 1ns/1ps
module eb_mem_model
(
    // Clock.
    input  wire logic        ref_clk,
    // Bus pins from the device.
    input  wire logic        addr_latch,
    input  wire logic        rd_n,
    input  wire logic        wrl_n,
    input  wire logic        wrh_n,
    input  wire logic        cs_n,
    input  wire logic [15:0] ad_o,
    input  wire logic [1:0]  ad_oe,
    // Resolved bus levels and captured write data.
    output logic      [15:0] ad_i,
    output logic      [15:0] wr_data
);
    logic [15:0] addr_q;
    logic [15:0] last_q;
    logic [15:0] drv;

    // The selected memory answers a read strobe, else the bus keeps changing.
    assign drv        = (!rd_n && !cs_n) ? ~addr_q : ~last_q;
    assign ad_i[7:0]  = ad_oe[0] ? ad_o[7:0] : drv[7:0];
    assign ad_i[15:8] = ad_oe[1] ? ad_o[15:8] : drv[15:8];

    // Catches the address phase and each strobed write lane.
    always_ff @(posedge ref_clk)
    begin
        last_q <= ad_i;
        if (addr_latch) addr_q <= ad_o;
        if (!wrl_n && !cs_n) wr_data[7:0] <= ad_o[7:0];
        if (!wrh_n && !cs_n) wr_data[15:8] <= ad_o[15:8];
    end
endmodule

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the external bus pin block.
// Assumes: Wait, bus request and mode pins idle high through their pull-ups.
// Notes:   Each scenario is one task that drives the block and judges it.
`timescale 1ns/1ps
module testbench;
    logic        ref_clk, rst_b, req_valid, req_ready, req_write, req_dummy;
    logic        resp_valid, func_sel_load, normal_mode_out, address_oe, addr_latch_out;
    logic        read_strobe_n, write_strobe_low_n, lo_oe, hi_oe, p30, p31;
    logic [1:0]  req_lanes;
    logic [23:0] req_addr;
    logic [15:0] req_wdata, resp_rdata, ad_i, wr_data;
    logic [9:0]  func_sel;
    logic [7:0]  addr_lo, addr_hi, lo_o, hi_o, port_lvl, pin_o, pin_oe, pin_pu, pin_lvl, ext_q;
    logic [7:0]  port_dir;
    int          miscompares = 0;
    int          tests_run = 0;

    // Clock at 40 MHz.
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Shared wires: the device level when enabled, else the outside drive or pull-up.
    assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext_q);

    eb_bus_pins u_eb_bus_pins (.ref_clk(ref_clk), .rst_b(rst_b), .req_valid(req_valid),
        .req_ready(req_ready), .req_write(req_write), .req_dummy(req_dummy),
        .req_lanes(req_lanes), .req_addr(req_addr), .req_wdata(req_wdata),
        .resp_valid(resp_valid), .resp_rdata(resp_rdata), .func_sel_in(func_sel),
        .func_sel_load(func_sel_load), .port3_output_bit_zero(p30),
        .port3_output_bit_one(p31), .port_out_in(8'hA5), .port_dir_in(port_dir),
        .port_level_out(port_lvl), .cs0_base_in(8'h12), .cs0_mask_in(8'hFF),
        .cs1_base_in(8'h80), .cs1_mask_in(8'hFF), .normal_mode_out(normal_mode_out),
        .address_low_out(addr_lo), .address_high_out(addr_hi), .address_oe(address_oe),
        .addr_latch_out(addr_latch_out), .read_strobe_n(read_strobe_n),
        .write_strobe_low_n(write_strobe_low_n), .muxed_addr_data_low_i(ad_i[7:0]),
        .muxed_addr_data_low_o(lo_o), .muxed_addr_data_low_oe(lo_oe),
        .muxed_addr_data_high_i(ad_i[15:8]), .muxed_addr_data_high_o(hi_o),
        .muxed_addr_data_high_oe(hi_oe), .shared_pin_i(pin_lvl), .shared_pin_o(pin_o),
        .shared_pin_oe(pin_oe), .shared_pin_pu(pin_pu));

    eb_mem_model u_eb_mem_model (.ref_clk(ref_clk), .addr_latch(addr_latch_out),
        .rd_n(read_strobe_n), .wrl_n(write_strobe_low_n), .wrh_n(pin_lvl[0]),
        .cs_n(pin_lvl[6]), .ad_o({hi_o, lo_o}), .ad_oe({hi_oe, lo_oe}), .ad_i(ad_i),
        .wr_data(wr_data));

    // Prints the counts and the verdict, then stops.
    task automatic end_sim;
        $display("TB: %0d compares, %0d mismatches", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Compares one value and counts the outcome.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Ends the run when a bounded wait ran out.
    task automatic guard(input logic ok);
        if (!ok)
        begin
            miscompares++;
            end_sim();
        end
    endtask

    // One core access; hold is the cycle at which a held wait is let go.
    task automatic access(input logic wr, input logic dm, input logic [1:0] ln,
                          input logic [23:0] ad, input logic [15:0] wd, input int hold);
        int n;
        int rd_c;
        int wl_c;
        int wh_c;
        int dl_c;
        int c0_c;
        int c1_c;
        logic [15:0] m;
        n = 0;
        rd_c = 0;
        wl_c = 0;
        wh_c = 0;
        dl_c = 0;
        c0_c = 0;
        c1_c = 0;
        m = {{8{ln[1]}}, {8{ln[0]}}};
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req_write <= wr;
        req_dummy <= dm;
        req_lanes <= ln;
        req_addr  <= ad;
        req_wdata <= wd;
        #1;
        while (req_ready !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        guard(n < 20);
        @(posedge ref_clk);
        req_valid <= 1'b0;
        #1;
        check(16'({addr_hi, addr_lo}), 16'({ad[23:16], ad[7:0]}));
        check(16'({addr_latch_out, lo_oe, lo_o}), 16'({2'b11, ad[7:0]}));
        n = 0;
        do
        begin
            @(posedge ref_clk);
            if (n == hold) ext_q[1] <= 1'b1;
            #1;
            n++;
            rd_c += int'(!read_strobe_n);
            wl_c += int'(!write_strobe_low_n);
            wh_c += int'(!pin_lvl[0]);
            dl_c += int'(!pin_lvl[4]);
            c0_c += int'(!pin_lvl[6]);
            c1_c += int'(!pin_lvl[7]);
        end
        while (resp_valid !== 1'b1 && n < 40);
        guard(n < 40);
        if (hold == 0)
        begin
            check(16'(n), 16'h0003);
            check(16'(rd_c), (!wr && !dm) ? 16'h0002 : 16'h0000);
            check(16'(wl_c), (wr && ln[0]) ? 16'h0002 : 16'h0000);
            check(16'(wh_c), (wr && ln[1]) ? 16'h0002 : 16'h0000);
        end
        else
        begin
            check(16'(n > hold && rd_c > 2), 16'h0001);
        end
        check(16'(dl_c > 0), 16'(wr));
        check(16'({c0_c > 0, c1_c > 0}), 16'h0002);
        if (wr)
            check(wr_data & m, wd & m);
        else if (!dm)
            check(resp_rdata, ~ad[15:0]);
    endtask

    // Port function after reset, then every pin handed to the bus.
    task automatic t_reset;
        check(16'({read_strobe_n, write_strobe_low_n}), 16'({p30, p31}));
        check({pin_o, pin_oe}, 16'hA50F);
        check(16'({pin_pu, normal_mode_out}), 16'h01E1);
        check(16'(port_lvl), 16'h00F5);
        @(posedge ref_clk);
        port_dir <= 8'hF0;
        @(posedge ref_clk);
        #1;
        check({pin_oe, pin_pu}, 16'hF00F);
        @(posedge ref_clk);
        func_sel      <= 10'h3FF;
        func_sel_load <= 1'b1;
        @(posedge ref_clk);
        func_sel_load <= 1'b0;
        $display("TB: test reset done");
    endtask

    // Writes on each lane choice, then a read and a dummy cycle.
    task automatic t_access;
        for (int i = 1; i < 4; i++)
            access(1'b1, 1'b0, 2'(i), 24'h12_3456 + 24'(i), 16'hC3A0 + 16'(i), 0);
        access(1'b0, 1'b0, 2'h3, 24'h12_9A5C, 16'h0000, 0);
        access(1'b0, 1'b1, 2'h3, 24'h12_0F0F, 16'h0000, 0);
        $display("TB: test access done");
    endtask

    // A read stalled by wait held low until eight cycles in.
    task automatic t_wait;
        @(posedge ref_clk);
        ext_q[1] <= 1'b0;
        repeat (4) @(posedge ref_clk);
        access(1'b0, 1'b0, 2'h3, 24'h12_7E81, 16'h0000, 8);
        $display("TB: test wait done");
    endtask

    // Outside master takes the bus and hands it back.
    task automatic t_handover;
        int n;
        logic rel;
        n = 0;
        rel = 1'b0;
        @(posedge ref_clk);
        ext_q[2] <= 1'b0;
        #1;
        while (pin_lvl[3] !== 1'b0 && n < 20)
        begin
            rel = (address_oe === 1'b0);
            @(posedge ref_clk);
            #1;
            n++;
        end
        guard(n < 20);
        check(16'({rel, address_oe, req_ready}), 16'h0004);
        @(posedge ref_clk);
        ext_q[2] <= 1'b1;
        n = 0;
        while (pin_lvl[3] !== 1'b1 && n < 20)
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        guard(n < 20);
        access(1'b0, 1'b0, 2'h3, 24'h12_0001, 16'h0000, 0);
        $display("TB: test handover done");
    endtask

    // Reset with the mode pin held high, then the scenarios.
    initial
    begin
        rst_b = 1'b0;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_dummy = 1'b0;
        req_lanes = 2'h0;
        req_addr = 24'h00_0000;
        req_wdata = 16'h0000;
        func_sel = 10'h000;
        func_sel_load = 1'b0;
        p30 = 1'b0;
        p31 = 1'b1;
        port_dir = 8'h0F;
        ext_q = 8'hFF;
        repeat (6) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        t_reset();
        t_access();
        t_wait();
        t_handover();
        end_sim();
    end
endmodule
